// *** include/pmau_pkg.sv ***
// pmau_pkg: constants and carriers for the program memory access unit.
// assumes a 25 MHz hclk and word-wide AHB-Lite register access.
`default_nettype none
package pmau_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0]  IDX_TABLE_PAGE  = 8'h32;
	localparam logic [7:0]  IDX_VIS_PAGE    = 8'h34;
	localparam logic [7:0]  IDX_CORE_CTRL   = 8'h44;
	localparam logic [7:0]  IDX_MEM_CTRL    = 8'h50;
	localparam logic [7:0]  IDX_UNLOCK_KEY  = 8'h52;
	localparam logic [15:0] RST_TABLE_PAGE  = 16'h0000;
	localparam logic [15:0] RST_VIS_PAGE    = 16'h0000;
	localparam logic [15:0] RST_CORE_CTRL   = 16'h0020;
	localparam logic [15:0] RST_MEM_CTRL    = 16'h0000;
	// core control and memory control fields, unlock key values
	localparam int          CC_WIN_EN_BIT   = 2;
	localparam int          MC_START_BIT    = 15;
	localparam int          MC_ERR_BIT      = 13;
	localparam logic [15:0] MC_WR_MASK      = 16'h000F;
	localparam logic [3:0]  OP_WORD         = 4'h1;
	localparam logic [3:0]  OP_ROW          = 4'h2;
	localparam logic [3:0]  OP_PAGE_ERASE   = 4'h3;
	localparam logic [7:0]  KEY_FIRST       = 8'h55;
	localparam logic [7:0]  KEY_SECOND      = 8'hAA;
	// window and array geometry, in program address units (2 per instr)
	localparam int          EA_LOW_BITS     = 15;
	localparam int          PAGE_BITS       = 8;
	localparam int          ROW_INSTR       = 64;
	localparam int          ROW_IDX_BITS    = 6;
	localparam logic [23:0] ROW_ALIGN_MASK  = 24'hFFFF80;
	localparam logic [23:0] PAGE_ALIGN_MASK = 24'hFFFC00;
	// timing: flash clock rate and documented row write length
	localparam int          CLK_HZ          = 25000000;
	localparam int          FRC_HZ          = 7370000;
	localparam int          ROW_FRC_CYC     = 11064;
	localparam int          ROW_CLK_CYC     = int'((64'(ROW_FRC_CYC) * CLK_HZ) / FRC_HZ);
	localparam int          WORD_CLK_CYC    = 2000;
	localparam int          ERASE_CLK_CYC   = 60000;
	localparam int          TMR_W           = 20;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN  = 3'b010,
		ST_DONE = 3'b100
	} pmau_state_e;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} pmau_rd_req_s;

	typedef struct packed {
		logic        go;
		logic [3:0]  op;
		logic [23:0] addr;
	} pmau_flash_cmd_s;
endpackage
`default_nettype wire

// *** rtl/pmau_top.sv ***
// pmau_top: program space window, holding buffers and flash sequencer.
// assumes one AHB-Lite master, a cpu data read port and a flash array
// that takes a command pulse and reads row data from the buffer port.
//
// Overview of operation
// - window read needs top address bit and enable
// - window covers data addresses 0x8000 upward
// - 8-bit page register selects 16K-word page
// - low 15 address bits below page bits
// - window read returns low 16 bits
// - window off during table read or write
// - outside repeat: copy +1, others +2
// - repeat: +2 first, last, interrupt edges
// - rows of 64 instr, pages of 512
// - pages and rows aligned from zero
// - page erase, row or word program
// - 64-entry buffers indexed by the table address
// - buffer table write takes two cycles
// - stall cpu while operation runs
// - durations timed from tuned fast oscillator
// - start bit 15 self-clears on completion
// - control register selects operation and start
// - write-only key, 0x55 then 0xAA
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module pmau_top
	import pmau_pkg::*;
#(
	parameter int ROW_CYC   = ROW_CLK_CYC,
	parameter int WORD_CYC  = WORD_CLK_CYC,
	parameter int ERASE_CYC = ERASE_CLK_CYC
) (
	// clock and reset
	input  wire logic            hclk,
	input  wire logic            hresetn,
	// ahb-lite slave
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic      [31:0]     hrdata,
	output logic                 hreadyout,
	output logic                 hresp,
	// cpu data read and instruction context
	input  wire pmau_rd_req_s    cpu_rd,
	input  wire logic            tbl_active,
	input  wire logic            copy_instr,
	input  wire logic            in_repeat,
	input  wire logic            rep_edge_iter,
	output logic                 win_hit,
	output logic      [15:0]     win_data,
	output logic                 win_data_valid,
	output logic      [1:0]      extra_cycles,
	output logic                 cpu_stall,
	// table writes into the holding buffers
	input  wire logic            tw_valid,
	input  wire logic            tw_high,
	input  wire logic [15:0]     tw_addr,
	input  wire logic [15:0]     tw_data,
	output logic                 tw_ready,
	output logic                 tw_done,
	// flash array side
	output logic      [23:0]     flash_rd_addr,
	output logic                 flash_rd_en,
	input  wire logic [23:0]     flash_rd_data,
	output pmau_flash_cmd_s      flash_cmd,
	input  wire logic [5:0]      buf_rd_idx,
	output logic      [23:0]     buf_rd_data,
	// oscillator tuning, two's complement
	input  wire logic [5:0]      osc_tuning_field
);

	// registers
	logic [15:0]     table_page_reg_q;
	logic [15:0]     visibility_page_reg_q;
	logic [15:0]     core_control_reg_q;
	logic [15:0]     memory_control_reg_q;
	logic [1:0]      key_stage_q;
	logic            dp_wr_q;
	logic [7:0]      dp_idx_q;
	logic            addr_ok_q;
	logic [31:0]     hrdata_q;
	logic            ap_valid;
	logic            ap_ok;
	logic [7:0]      ap_idx;
	logic            wr_strobe;
	logic            start_req;
	pmau_state_e     state_q;
	logic [TMR_W-1:0] tmr_q;
	logic [TMR_W-1:0] dur;
	logic [23:0]     buf_mem [ROW_INSTR];
	logic [15:0]     tw_last_q;
	logic            tw_busy_q;
	logic            win_pend_q;
	pmau_flash_cmd_s cmd_q;
	logic [15:0]     win_data_q;
	logic            win_valid_q;
	logic            wr_table_page;
	logic            wr_vis_page;
	logic            wr_core_ctrl;
	logic            wr_mem_ctrl;
	logic            wr_key;
	logic [5:0]      tun_mag;

	function automatic logic [31:0] reg_read(input logic [7:0] idx,
		input logic [15:0] tp, input logic [15:0] vp,
		input logic [15:0] cc, input logic [15:0] mc);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (idx)
			IDX_TABLE_PAGE: v = {16'h0000, 8'h00, tp[7:0]};
			IDX_VIS_PAGE:   v = {16'h0000, 8'h00, vp[7:0]};
			IDX_CORE_CTRL:  v = {16'h0000, cc};
			IDX_MEM_CTRL:   v = {16'h0000, mc};
			default:        v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	function automatic logic idx_known(input logic [7:0] idx);
		return idx == IDX_TABLE_PAGE || idx == IDX_VIS_PAGE ||
			idx == IDX_CORE_CTRL || idx == IDX_MEM_CTRL ||
			idx == IDX_UNLOCK_KEY;
	endfunction

	function automatic logic [23:0] flash_target(input logic [7:0] tp, input logic [15:0] off,
		input logic [23:0] mask);
		return {tp, off} & mask;
	endfunction

	// address phase decode; only word accesses on aligned offsets map
	// upper address bits must be zero, so no offset aliases a register
	assign ap_valid  = hsel && hready && htrans[1];
	assign ap_idx    = haddr[9:2];
	assign ap_ok     = idx_known(ap_idx) && haddr[31:10] == 22'h0 &&
		haddr[1:0] == 2'b00 && hsize == 3'b010;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	assign wr_strobe = dp_wr_q && addr_ok_q;
	// one strobe per register, valid in the write data phase
	assign wr_table_page = wr_strobe && dp_idx_q == IDX_TABLE_PAGE;
	assign wr_vis_page   = wr_strobe && dp_idx_q == IDX_VIS_PAGE;
	assign wr_core_ctrl  = wr_strobe && dp_idx_q == IDX_CORE_CTRL;
	assign wr_mem_ctrl   = wr_strobe && dp_idx_q == IDX_MEM_CTRL;
	assign wr_key        = wr_strobe && dp_idx_q == IDX_UNLOCK_KEY;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q   <= 1'b0;
			dp_idx_q  <= 8'h00;
			addr_ok_q <= 1'b0;
		end else begin
			dp_wr_q   <= ap_valid && hwrite;
			dp_idx_q  <= ap_idx;
			addr_ok_q <= ap_ok;
		end
	end

	// read data captured at the address edge so it comes from a flop;
	// the key register reads as zero, unmapped offsets too
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (ap_valid && !hwrite) begin
			hrdata_q <= ap_ok ? reg_read(ap_idx, table_page_reg_q, visibility_page_reg_q,
				core_control_reg_q, memory_control_reg_q) : 32'h0000_0000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			table_page_reg_q      <= RST_TABLE_PAGE;
			visibility_page_reg_q <= RST_VIS_PAGE;
			core_control_reg_q    <= RST_CORE_CTRL;
		end else if (wr_strobe) begin
			if (wr_table_page) begin
				table_page_reg_q <= {8'h00, hwdata[7:0]};
			end
			if (wr_vis_page) begin
				visibility_page_reg_q <= {8'h00, hwdata[PAGE_BITS-1:0]};
			end
			if (wr_core_ctrl) begin
				core_control_reg_q <= hwdata[15:0];
			end
		end
	end

	// unlock: stage 1 after the first key, stage 2 after the second;
	// any other register write drops back, so the pair must be back to back
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			key_stage_q <= 2'd0;
		end else if (wr_strobe) begin
			if (wr_key && hwdata[7:0] == KEY_FIRST) begin
				key_stage_q <= 2'd1;
			end else if (wr_key && hwdata[7:0] == KEY_SECOND &&
				key_stage_q == 2'd1) begin
				key_stage_q <= 2'd2;
			end else begin
				key_stage_q <= 2'd0;
			end
		end
	end

	assign start_req = wr_mem_ctrl &&
		hwdata[MC_START_BIT] && key_stage_q == 2'd2 && state_q == ST_IDLE;

	// control register: op select bits writable only while idle; the
	// start bit is set by an unlocked write and cleared by the sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			memory_control_reg_q <= RST_MEM_CTRL;
		end else if (start_req) begin
			memory_control_reg_q <= (hwdata[15:0] & MC_WR_MASK) |
				(16'h0001 << MC_START_BIT);
		end else if (state_q == ST_DONE) begin
			memory_control_reg_q[MC_START_BIT] <= 1'b0;
		end else if (wr_mem_ctrl && state_q == ST_IDLE) begin
			memory_control_reg_q <= (memory_control_reg_q & ~MC_WR_MASK) |
				(hwdata[15:0] & MC_WR_MASK);
		end
	end

	// tuning magnitude kept at six bits so the negation cannot carry upward
	always_comb begin
		if (osc_tuning_field[5]) begin
			tun_mag = 6'(~osc_tuning_field + 6'd1);
		end else begin
			tun_mag = osc_tuning_field;
		end
	end

	// duration from the tuned oscillator: each tuning step moves the
	// rate by about 0.39 percent, approximated by base/256 per step
	always_comb begin
		logic [TMR_W-1:0] base;
		logic [TMR_W-1:0] step;
		base = TMR_W'(ROW_CYC);
		step = '0;
		unique case (hwdata[3:0])
			OP_WORD:       base = TMR_W'(WORD_CYC);
			OP_PAGE_ERASE: base = TMR_W'(ERASE_CYC);
			default:       base = TMR_W'(ROW_CYC);
		endcase
		step = base >> 8;
		if (osc_tuning_field[5]) begin
			dur = base + step * TMR_W'(tun_mag);
		end else begin
			dur = base - step * TMR_W'(tun_mag);
		end
	end

	// sequencer
	// one-hot states: a corrupted code falls back to idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_IDLE;
			tmr_q   <= '0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (start_req) begin
						state_q <= ST_RUN;
						tmr_q   <= dur;
					end
				end
				ST_RUN: begin
					if (tmr_q <= TMR_W'(1)) begin
						state_q <= ST_DONE;
					end
					tmr_q <= tmr_q - TMR_W'(1);
				end
				ST_DONE: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// flash command: aligned target from the table page and last write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_q <= '0;
		end else begin
			cmd_q.go <= start_req;
			if (start_req) begin
				cmd_q.op <= hwdata[3:0];
				// word program keeps the exact address; row and page round down
				unique case (hwdata[3:0])
					OP_PAGE_ERASE: cmd_q.addr <= flash_target(table_page_reg_q[7:0], tw_last_q,
						PAGE_ALIGN_MASK);
					OP_ROW:        cmd_q.addr <= flash_target(table_page_reg_q[7:0], tw_last_q,
						ROW_ALIGN_MASK);
					default:       cmd_q.addr <= flash_target(table_page_reg_q[7:0], tw_last_q,
						'1);
				endcase
			end
		end
	end
	assign flash_cmd = cmd_q;
	assign cpu_stall = state_q != ST_IDLE;

	// holding buffers, 64 instructions; index from the table address
	// so software must keep to one 64-instruction group
	assign tw_ready = state_q == ST_IDLE && !tw_busy_q;
	always_ff @(posedge hclk) begin
		if (tw_valid && tw_ready) begin
			if (tw_high) begin
				buf_mem[tw_addr[ROW_IDX_BITS:1]][23:16] <= tw_data[7:0];
			end else begin
				buf_mem[tw_addr[ROW_IDX_BITS:1]][15:0] <= tw_data;
			end
		end
	end
	assign buf_rd_data = buf_mem[buf_rd_idx];

	// a buffer write occupies two cycles: accept, then done pulse
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tw_busy_q <= 1'b0;
			tw_last_q <= 16'h0000;
		end else begin
			tw_busy_q <= tw_valid && tw_ready;
			if (tw_valid && tw_ready) begin
				tw_last_q <= tw_addr;
			end
		end
	end
	assign tw_done = tw_busy_q;

	// program space window
	assign win_hit = cpu_rd.valid && cpu_rd.addr[15] &&
		core_control_reg_q[CC_WIN_EN_BIT] && !tbl_active && !tw_busy_q;
	assign flash_rd_en   = win_hit;
	// low address bits pass straight through; the top bit stays zero
	assign flash_rd_addr = {1'b0, visibility_page_reg_q[PAGE_BITS-1:0],
		cpu_rd.addr[EA_LOW_BITS-1:0]};

	always_comb begin
		if (!win_hit) begin
			extra_cycles = 2'd0;
		end else if (in_repeat) begin
			extra_cycles = rep_edge_iter ? 2'd2 : 2'd0;
		end else begin
			extra_cycles = copy_instr ? 2'd1 : 2'd2;
		end
	end

	// array data returns one cycle after the window address
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			win_pend_q  <= 1'b0;
			win_data_q  <= 16'h0000;
			win_valid_q <= 1'b0;
		end else begin
			win_pend_q  <= win_hit;
			win_valid_q <= win_pend_q;
			if (win_pend_q) begin
				win_data_q <= flash_rd_data[15:0];
			end
		end
	end
	assign win_data       = win_data_q;
	assign win_data_valid = win_valid_q;

endmodule
`default_nettype wire

// *** tb/pmau_props.sv ***
// pmau_props: port checks on window, holding buffer and sequencer.
// assumes binding onto pmau_top, duration parameters handed on.
`timescale 1ns/10ps
`default_nettype none
module pmau_props
	import pmau_pkg::*;
#(
	parameter int ROW_CYC   = 20,
	parameter int WORD_CYC  = 10,
	parameter int ERASE_CYC = 30
) (
	// clock and reset
	input wire logic            hclk,
	input wire logic            hresetn,
	// cpu side
	input wire pmau_rd_req_s    cpu_rd,
	input wire logic            tbl_active,
	input wire logic            copy_instr,
	input wire logic            in_repeat,
	input wire logic            rep_edge_iter,
	input wire logic            win_hit,
	input wire logic [15:0]     win_data,
	input wire logic            win_data_valid,
	input wire logic [1:0]      extra_cycles,
	input wire logic            cpu_stall,
	input wire logic            tw_valid,
	input wire logic            tw_ready,
	input wire logic            tw_done,
	// flash side
	input wire logic [23:0]     flash_rd_addr,
	input wire logic [23:0]     flash_rd_data,
	input wire pmau_flash_cmd_s flash_cmd
);
	logic [15:0] stall_q;
	logic [3:0]  op_q;
	logic [15:0] want;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			stall_q <= 16'h0000;
		else
			stall_q <= cpu_stall ? stall_q + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			op_q <= 4'h0;
		else if (flash_cmd.go)
			op_q <= flash_cmd.op;
	end
	// stall covers the run plus the one done cycle
	assign want = 16'(op_q == OP_ROW ? ROW_CYC : op_q == OP_WORD ? WORD_CYC : ERASE_CYC) + 16'h0001;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_go_pulse;
		flash_cmd.go ##1 !flash_cmd.go;
	endsequence
	sequence s_data_back;
		##2 win_data_valid;
	endsequence
	a_hit_cause: assert property (win_hit |-> cpu_rd.valid && cpu_rd.addr[15]) else $error("window hit without cause");
	a_tbl_blocks: assert property (tbl_active |-> !win_hit) else $error("window hit during table op");
	a_addr_low: assert property (win_hit |-> flash_rd_addr[14:0] == cpu_rd.addr[14:0]) else $error("array address low bits wrong");
	a_data_late: assert property (win_hit |-> s_data_back) else $error("window data not returned");
	a_data_low: assert property (win_data_valid |-> win_data == $past(flash_rd_data[15:0])) else $error("window data not low half");
	a_pen_out: assert property (win_hit && !in_repeat |-> extra_cycles == (copy_instr ? 2'd1 : 2'd2)) else $error("penalty outside loop wrong");
	a_pen_rep: assert property (win_hit && in_repeat |-> extra_cycles == (rep_edge_iter ? 2'd2 : 2'd0)) else $error("penalty inside loop wrong");
	a_pen_none: assert property (!win_hit |-> extra_cycles == 2'd0) else $error("penalty without hit");
	a_go_stall: assert property ($rose(cpu_stall) |-> s_go_pulse) else $error("stall without single go pulse");
	a_stall_len: assert property ($fell(cpu_stall) |-> stall_q == want) else $error("stall length wrong");
	a_tw_step: assert property (tw_valid && tw_ready |=> tw_done && !tw_ready) else $error("buffer write not two cycles");
	a_row_align: assert property (flash_cmd.go && flash_cmd.op == OP_ROW |-> (flash_cmd.addr & ~ROW_ALIGN_MASK) == 24'h000000) else $error("row target misaligned");
	a_page_align: assert property (flash_cmd.go && flash_cmd.op == OP_PAGE_ERASE |-> (flash_cmd.addr & ~PAGE_ALIGN_MASK) == 24'h000000) else $error("page target misaligned");
endmodule
bind pmau_top pmau_props #(.ROW_CYC(ROW_CYC), .WORD_CYC(WORD_CYC), .ERASE_CYC(ERASE_CYC))
	pmau_props_inst (
	.hclk(hclk), .hresetn(hresetn), .cpu_rd(cpu_rd), .tbl_active(tbl_active),
	.copy_instr(copy_instr), .in_repeat(in_repeat), .rep_edge_iter(rep_edge_iter),
	.win_hit(win_hit), .win_data(win_data), .win_data_valid(win_data_valid),
	.extra_cycles(extra_cycles), .cpu_stall(cpu_stall), .tw_valid(tw_valid),
	.tw_ready(tw_ready), .tw_done(tw_done), .flash_rd_addr(flash_rd_addr),
	.flash_rd_data(flash_rd_data), .flash_cmd(flash_cmd));
`default_nettype wire

// *** tb/pmau_flash_model.sv ***
// pmau_flash_model: flash array answering window reads, copying the row buffer.
// assumes the sequencer's go pulse and the buffer read port of pmau_top.
`timescale 1ns/10ps
`default_nettype none
module pmau_flash_model
	import pmau_pkg::*;
(
	// clock and reset
	input  wire logic            hclk,
	input  wire logic            hresetn,
	// array read and program
	input  wire logic            flash_rd_en,
	input  wire logic [23:0]     flash_rd_addr,
	output logic      [23:0]     flash_rd_data,
	input  wire pmau_flash_cmd_s flash_cmd,
	output logic      [5:0]      buf_rd_idx,
	input  wire logic [23:0]     buf_rd_data
);
	logic [23:0] row_img [64];
	logic        copy_q;
	// upper byte all ones so stray execution is a no-op; idle data toggles
	always @(posedge hclk) begin
		if (!hresetn)
			flash_rd_data <= 24'h5A5A5A;
		else if (flash_rd_en)
			flash_rd_data <= {8'hFF, flash_rd_addr[23:8] ^ flash_rd_addr[15:0]};
		else
			flash_rd_data <= ~flash_rd_data;
	end
	// one whole row of 64 words taken per go pulse
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			copy_q <= 1'b0;
			buf_rd_idx <= 6'h00;
		end else if (flash_cmd.go) begin
			copy_q <= 1'b1;
			buf_rd_idx <= 6'h00;
		end else if (copy_q) begin
			row_img[buf_rd_idx] <= buf_rd_data;
			buf_rd_idx <= buf_rd_idx + 6'h01;
			copy_q <= buf_rd_idx != 6'h3F;
		end
	end
endmodule
`default_nettype wire

// *** tb/program_memory_access_unit_tb_top.sv ***
// program_memory_access_unit_tb_top: self-checking bench for pmau_top.
// assumes the flash model and the bound checker compile alongside.
`timescale 1ns/10ps
`default_nettype none
module program_memory_access_unit_tb_top
	import pmau_pkg::*;
;
	logic            hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0]     haddr = '0, hwdata = '0, hrdata;
	logic [1:0]      htrans = '0, extra_cycles;
	logic [2:0]      hsize = 3'd2;
	logic            hreadyout, hresp, win_hit, win_data_valid, cpu_stall, tw_ready, tw_done;
	wire logic       hready;
	pmau_rd_req_s    cpu_rd = '0;
	logic            tbl_active = 0, copy_instr = 0, in_repeat = 0, rep_edge_iter = 0;
	logic            tw_valid = 0, tw_high = 0, flash_rd_en;
	logic [15:0]     tw_addr = '0, tw_data = '0, win_data;
	logic [23:0]     flash_rd_addr, flash_rd_data, buf_rd_data;
	logic [5:0]      buf_rd_idx, osc_tuning_field = '0;
	pmau_flash_cmd_s flash_cmd;
	logic [15:0]     exp_q [$];
	int              n_errors = 0, check_count = 0;
	localparam logic [31:0] RA [6] = '{32'hC8, 32'hD0, 32'h110, 32'h140, 32'h148, 32'h3FC};
	localparam logic [31:0] RV [6] = '{32'h0, 32'h0, 32'h20, 32'h0, 32'h0, 32'h0};
	assign hready = hreadyout;
	always #20 hclk = ~hclk;
	pmau_top #(.ROW_CYC(20), .WORD_CYC(10), .ERASE_CYC(30)) pmau_top_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cpu_rd(cpu_rd), .tbl_active(tbl_active),
		.copy_instr(copy_instr), .in_repeat(in_repeat), .rep_edge_iter(rep_edge_iter),
		.win_hit(win_hit), .win_data(win_data), .win_data_valid(win_data_valid),
		.extra_cycles(extra_cycles), .cpu_stall(cpu_stall), .tw_valid(tw_valid),
		.tw_high(tw_high), .tw_addr(tw_addr), .tw_data(tw_data), .tw_ready(tw_ready),
		.tw_done(tw_done), .flash_rd_addr(flash_rd_addr), .flash_rd_en(flash_rd_en),
		.flash_rd_data(flash_rd_data), .flash_cmd(flash_cmd), .buf_rd_idx(buf_rd_idx),
		.buf_rd_data(buf_rd_data), .osc_tuning_field(osc_tuning_field));
	pmau_flash_model pmau_flash_model_inst (
		.hclk(hclk), .hresetn(hresetn), .flash_rd_en(flash_rd_en),
		.flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data), .flash_cmd(flash_cmd),
		.buf_rd_idx(buf_rd_idx), .buf_rd_data(buf_rd_data));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		@(posedge hclk);
		{hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, w};
		do @(posedge hclk); while (hready !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
		check(hresp, 1'b0);
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rdc(input logic [31:0] a, exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		check(r, exp);
	endtask
	task automatic win(input logic [15:0] a, input logic [3:0] ctx, input logic hit, input logic [7:0] pg);
		logic [23:0] pa;
		pa = {1'b0, pg, a[14:0]};
		@(posedge hclk);
		cpu_rd <= '{valid: 1'b1, addr: a};
		{tbl_active, copy_instr, in_repeat, rep_edge_iter} <= ctx;
		#1 check(win_hit, hit);
		check(extra_cycles, !hit ? 0 : !ctx[1] ? (ctx[2] ? 1 : 2) : (ctx[0] ? 2 : 0));
		if (hit)
			exp_q.push_back(pa[23:8] ^ pa[15:0]);
		@(posedge hclk);
		cpu_rd <= '0;
	endtask
	task automatic tw(input logic hi, input logic [15:0] a, d);
		@(posedge hclk);
		{tw_valid, tw_high, tw_addr, tw_data} <= {1'b1, hi, a, d};
		do @(posedge hclk); while (tw_ready !== 1'b1);
		tw_valid <= 1'b0;
		#1 check(tw_done, 1);
	endtask
	task automatic run(input logic [3:0] op);
		wr(32'h140, op);
		wr(32'h148, 32'h55);
		wr(32'h148, 32'hAA);
		wr(32'h140, 32'h8000 | op);
		#1 check(cpu_stall, 1);
		rdc(32'h140, 32'h8000 | op);
		while (cpu_stall === 1'b1) @(posedge hclk);
		rdc(32'h140, op);
	endtask
	// results come back two cycles late, so a second process pairs them
	always @(negedge hclk) begin
		if (win_data_valid === 1'b1)
			check(win_data, exp_q.size() != 0 ? exp_q.pop_front() : 16'hXXXX);
	end
	initial begin
		#1200000;
		n_errors++;
		$display("Error at %0t: watchdog expired", $time);
		end_of_test();
	end
	initial begin
		logic [7:0]  pg;
		logic [15:0] lo, hi;
		logic [23:0] img [64];
		void'($urandom(16521));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (RA[i]) rdc(RA[i], RV[i]);
		$display("test reset values done");
		pg = 8'($urandom);
		wr(32'hD0, {24'hFFFFFF, pg});
		rdc(32'hD0, pg);
		win(16'h8000, 4'h0, 0, pg);
		wr(32'h110, 32'h24);
		for (int k = 0; k < 8; k++) win({1'b1, 15'($urandom)}, 4'(k), 1, pg);
		win(16'h7FFF, 4'h0, 0, pg);
		win(16'hFFFF, 4'h0, 1, pg);
		win(16'h9000, 4'h8, 0, pg);
		repeat (4) @(posedge hclk);
		check(exp_q.size(), 0);
		$display("test window done");
		wr(32'hC8, 32'($urandom) & 32'hFF);
		osc_tuning_field <= 6'($urandom);
		for (int i = 0; i < 64; i++) begin
			lo = 16'($urandom);
			hi = 16'($urandom);
			img[i] = {hi[7:0], lo};
			tw(1'b0, 16'h0180 + 16'(2 * i), lo);
			tw(1'b1, 16'h0180 + 16'(2 * i), hi);
		end
		run(OP_ROW);
		repeat (70) @(posedge hclk);
		foreach (img[i]) check(pmau_flash_model_inst.row_img[i], img[i]);
		run(OP_WORD);
		run(OP_PAGE_ERASE);
		$display("test programming done");
		wr(32'h148, 32'h55);
		wr(32'hD0, pg);
		wr(32'h148, 32'hAA);
		wr(32'h140, 32'h8002);
		#1 check(cpu_stall, 0);
		rdc(32'h140, 32'h0002);
		$display("test broken unlock done");
		end_of_test();
	end
endmodule
`default_nettype wire
